/* pwm_chan_params.svh */
// Constants for the pulse width channel block: offsets, fields, resets.
// Assumes inclusion by the channel modules, the checker and the testbench.
`ifndef PWM_CHAN_PARAMS_SVH
`define PWM_CHAN_PARAMS_SVH

// Register byte offsets on the APB word map
`define OFF_MODE      12'h000
`define OFF_ENABLE    12'h004
`define OFF_DISABLE   12'h008
`define OFF_STATUS    12'h00c
`define OFF_PERIOD    12'h010
`define OFF_DUTY      12'h014
`define OFF_UPDATE    12'h018
`define OFF_COUNTER   12'h01c

// Mode register fields
`define MODE_PRE_LSB  0
`define MODE_PRE_MSB  3
`define MODE_UPD_BIT  8

// Update select bit, unused: mode bit 8 selects 0 duty, 1 period
`define UPD_SEL_BIT   0

// Enable and disable command bit
`define CMD_BIT       0

// Reset values
`define RST_PERIOD    16'h0001
`define RST_DUTY      16'h0001
`define RST_PRE       4'h0

// Counter start values
`define CNT_FIRST     16'h0000
`define CNT_NEXT      16'h0001
`define CNT_ZERO      16'h0000
`define CNT_ONE       16'h0001

`define DATA_ZERO     32'h0000_0000
`endif

/* pwm_chan_pkg.sv */
// Types shared by the pulse width channel modules.
// Assumes the params header is on the include path.
package pwm_chan_pkg;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_FIRST = 2'b01,
    CH_RUN = 2'b10
  } chan_state_t;
endpackage

/* clk_select.sv */
// Prescaled tick for the channel counter: one pulse each 2^sel cycles.
// Assumes sel is steady from the same clock domain.
`timescale 1ns/1ps
`include "pwm_chan_params.svh"
module clk_select #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Control
  input wire logic run,
  input wire logic [3:0] sel,
  // Tick out
  output logic tick
);
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [DIV_W-1:0] mask;

  assign mask = DIV_W'((32'h1 << sel) - 32'h1);
  assign div_d = run ? DIV_W'(div_q + 1'b1) : '0;
  assign tick = run && ((div_q & mask) == mask);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) div_q <= '0;
    else div_q <= div_d;
  end
endmodule // clk_select

/* pwm_channel_update_quirks.sv */
// One pulse width channel with APB register access and its update quirks.
// Assumes an APB master on clk_sys; the pin mux lives outside.
//
// Notes on behaviour
// - counter 0 or 1: update applies immediately
// - zero period blocks requested period updates
// - left aligned: first start 0, then 1
// - early disable: output off, flag stays
`timescale 1ns/1ps
`include "pwm_chan_params.svh"
module pwm_channel_update_quirks
  import pwm_chan_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Waveform
  output logic pwmOut
);
  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic wrEn, rdEn;
  logic wrMode, wrEnable, wrDisable, wrPeriod, wrDuty, wrUpdate;
  logic mapped;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign wrMode = wrEn && hit(paddr, `OFF_MODE);
  assign wrEnable = wrEn && hit(paddr, `OFF_ENABLE) && pwdata[`CMD_BIT];
  assign wrDisable = wrEn && hit(paddr, `OFF_DISABLE) && pwdata[`CMD_BIT];
  assign wrPeriod = wrEn && hit(paddr, `OFF_PERIOD);
  assign wrDuty = wrEn && hit(paddr, `OFF_DUTY);
  assign wrUpdate = wrEn && hit(paddr, `OFF_UPDATE);
  assign mapped = hit(paddr, `OFF_MODE) || hit(paddr, `OFF_ENABLE) ||
                  hit(paddr, `OFF_DISABLE) || hit(paddr, `OFF_STATUS) ||
                  hit(paddr, `OFF_PERIOD) || hit(paddr, `OFF_DUTY) ||
                  hit(paddr, `OFF_UPDATE) || hit(paddr, `OFF_COUNTER);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [3:0] pre_q;
  logic updPeriodSel_q;
  logic [CNT_W-1:0] channel_period_value_q;
  logic [CNT_W-1:0] channel_duty_value_q;
  logic [CNT_W-1:0] pendVal_q;
  logic pend_q, pendPer_q;
  logic [CNT_W-1:0] channel_counter_value_q, cnt_d;
  logic channel_enabled_flag_q;
  logic outEn_q;
  logic tickSeen_q;
  logic [31:0] rdMux, prdata_q;
  chan_state_t st_q, st_d;
  logic tick, periodEnd, immed, applyNow, applyEnd;
  logic channel_disable_command;

  assign channel_disable_command = wrDisable;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pre_q <= `RST_PRE;
      updPeriodSel_q <= 1'b0;
    end else if (wrMode) begin
      pre_q <= pwdata[`MODE_PRE_MSB:`MODE_PRE_LSB];
      updPeriodSel_q <= pwdata[`MODE_UPD_BIT];
    end
  end

  // ------------------------------------------------------------
  // Channel clock and counter
  // ------------------------------------------------------------
  clk_select #(.DIV_W(CNT_W)) u_clk (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(outEn_q),
    .sel(pre_q),
    .tick(tick)
  );

  assign periodEnd = tick &&
    (channel_counter_value_q >= channel_period_value_q);

  always_comb begin
    st_d = st_q;
    cnt_d = channel_counter_value_q;
    unique case (st_q)
      CH_IDLE: begin
        if (wrEnable) begin
          st_d = CH_FIRST;
          cnt_d = `CNT_FIRST;
        end
      end
      CH_FIRST, CH_RUN: begin
        if (channel_disable_command) begin
          st_d = CH_IDLE;
        end else if (periodEnd) begin
          st_d = CH_RUN;
          cnt_d = `CNT_NEXT;
        end else if (tick) begin
          cnt_d = CNT_W'(channel_counter_value_q + 1'b1);
        end
      end
      default: st_d = CH_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= CH_IDLE;
      channel_counter_value_q <= `CNT_ZERO;
    end else begin
      st_q <= st_d;
      channel_counter_value_q <= cnt_d;
    end
  end

  // ------------------------------------------------------------
  // Enable, status and early-disable quirk
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      outEn_q <= 1'b0;
      channel_enabled_flag_q <= 1'b0;
      tickSeen_q <= 1'b0;
    end else begin
      if (wrEnable && st_q == CH_IDLE) begin
        outEn_q <= 1'b1;
        channel_enabled_flag_q <= 1'b1;
        tickSeen_q <= 1'b0;
      end else if (channel_disable_command) begin
        outEn_q <= 1'b0;
        // flag sticks if no clock period yet
        if (tickSeen_q || tick) channel_enabled_flag_q <= 1'b0;
      end else if (tick) begin
        tickSeen_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Period and duty update path
  // ------------------------------------------------------------
  // counter at 0 or 1 bypasses deferral
  assign immed = channel_counter_value_q == `CNT_ZERO ||
                 channel_counter_value_q == `CNT_ONE;
  // no period update while period is zero
  assign applyNow = wrUpdate && immed &&
    !(updPeriodSel_q && channel_period_value_q == '0);
  // deferred update lands at period end
  assign applyEnd = pend_q && periodEnd &&
    !(pendPer_q && channel_period_value_q == '0);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      channel_period_value_q <= `RST_PERIOD;
      channel_duty_value_q <= `RST_DUTY;
      pendVal_q <= '0;
      pend_q <= 1'b0;
      pendPer_q <= 1'b0;
    end else begin
      if (wrPeriod) channel_period_value_q <= pwdata[CNT_W-1:0];
      if (wrDuty) channel_duty_value_q <= pwdata[CNT_W-1:0];
      if (applyNow) begin
        if (updPeriodSel_q) channel_period_value_q <= pwdata[CNT_W-1:0];
        else channel_duty_value_q <= pwdata[CNT_W-1:0];
        pend_q <= 1'b0;
      end else if (wrUpdate && !immed) begin
        pendVal_q <= pwdata[CNT_W-1:0];
        pendPer_q <= updPeriodSel_q;
        pend_q <= 1'b1;
      end else if (applyEnd) begin
        if (pendPer_q) channel_period_value_q <= pendVal_q;
        else channel_duty_value_q <= pendVal_q;
        pend_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Output and read data
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) pwmOut <= 1'b0;
    else pwmOut <= outEn_q &&
      (channel_counter_value_q < channel_duty_value_q);
  end

  always_comb begin
    unique case (paddr)
      `OFF_MODE: rdMux = {23'h0, updPeriodSel_q, 4'h0, pre_q};
      `OFF_STATUS: rdMux = {31'h0, channel_enabled_flag_q};
      `OFF_PERIOD: rdMux = {16'h0, channel_period_value_q};
      `OFF_DUTY: rdMux = {16'h0, channel_duty_value_q};
      `OFF_COUNTER: rdMux = {16'h0, channel_counter_value_q};
      default: rdMux = `DATA_ZERO;
    endcase
  end

  // Read data latched in setup so it stands through the access phase
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) prdata_q <= `DATA_ZERO;
    else if (psel && !penable && !pwrite) prdata_q <= rdMux;
  end
  assign prdata = rdEn ? prdata_q : `DATA_ZERO;
endmodule // pwm_channel_update_quirks

/* pwm_channel_update_quirks_assertions.sv */
// Checker for the pulse width channel: APB answers and output gating.
// Assumes it sees only the top module's ports; bound at the foot.
`timescale 1ns/1ps
`include "pwm_chan_params.svh"
module pwm_channel_update_quirks_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Waveform
  input wire logic pwmOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic runQ_q;
  wire wrOn = psel && penable && pwrite;
  wire enHit = wrOn && paddr == `OFF_ENABLE && pwdata[0];
  wire disHit = wrOn && paddr == `OFF_DISABLE && pwdata[0];
  // Software intent, not the status bit, which may stick
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) runQ_q <= 1'b0;
    else if (disHit) runQ_q <= 1'b0;
    else if (enHit) runQ_q <= 1'b1;
  end
  sequence s_disable; disHit; endsequence
  sequence s_quiet; !pwmOut [*2]; endsequence
  property p_dis_off; s_disable |-> ##2 s_quiet; endproperty
  property p_run; pwmOut |-> $past(runQ_q); endproperty
  property p_ready; psel && penable |-> pready; endproperty
  property p_err; pslverr |-> psel && penable; endproperty
  property p_rdata;
    !(psel && penable && !pwrite) |-> prdata == 32'h0000_0000;
  endproperty
  a_dis_off: assert property (p_dis_off) else $error("output on after disable");
  a_run: assert property (p_run) else $error("output high while stopped");
  a_ready: assert property (p_ready) else $error("no ready in access");
  a_err: assert property (p_err) else $error("error outside access");
  a_rdata: assert property (p_rdata) else $error("read data not zero");
endmodule // pwm_channel_update_quirks_assertions

bind pwm_channel_update_quirks pwm_channel_update_quirks_assertions
  pwm_channel_update_quirks_assertions_i (.clk_sys(clk_sys),
  .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pwmOut(pwmOut));

/* testbench.sv */
// Self-checking bench for the pulse width channel over APB.
// Assumes the params header is on the include path; 40 MHz clock.
`timescale 1ns/1ps
`include "pwm_chan_params.svh"
module testbench;
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, pwmOut;
  logic err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] seed;
  logic [15:0] v;
  int error_cnt, tests_run, i;
  pwm_channel_update_quirks pwm_channel_update_quirks_i (.clk_sys(clk_sys),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwmOut(pwmOut));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer; holds the request until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      error_cnt++;
      $display("[FAIL] %0t no ready", $time);
      results();
    end
  endtask
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    seed = 8'h5f;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    apb(1'b0, `OFF_PERIOD, 32'h0); chk(rd, 32'h1);
    apb(1'b0, `OFF_STATUS, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0); chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      v = {seed, lfsr(seed)} | 16'h1;
      apb(1'b1, i[0] ? `OFF_DUTY : `OFF_PERIOD, {seed, seed, v});
      apb(1'b0, i[0] ? `OFF_DUTY : `OFF_PERIOD, 32'h0);
      chk(rd, {16'h0, v});
    end
    $display("Reset, map and random test done");
    // Period updates, 16 cycles per counter tick
    apb(1'b1, `OFF_MODE, 32'h0000_0104);
    apb(1'b1, `OFF_PERIOD, 32'h6);
    apb(1'b1, `OFF_DUTY, 32'h2);
    apb(1'b1, `OFF_ENABLE, 32'h1);
    apb(1'b0, `OFF_COUNTER, 32'h0); chk(rd, 32'h0);
    apb(1'b1, `OFF_UPDATE, 32'h7);
    apb(1'b0, `OFF_PERIOD, 32'h0); chk(rd, 32'h7);
    i = 0;
    do begin
      apb(1'b0, `OFF_COUNTER, 32'h0);
      i++;
    end while (rd < 32'h2 && i < 200);
    if (rd < 32'h2) begin
      error_cnt++;
      $display("[FAIL] %0t counter never reached two", $time);
      results();
    end
    apb(1'b1, `OFF_UPDATE, 32'h3);
    apb(1'b0, `OFF_PERIOD, 32'h0); chk(rd, 32'h7);
    // Fresh counter sample, so the loop starts from a count
    apb(1'b0, `OFF_COUNTER, 32'h0);
    i = 0;
    do begin
      v = rd[15:0];
      apb(1'b0, `OFF_COUNTER, 32'h0);
      i++;
    end while (rd >= {16'h0, v} && i < 400);
    if (rd >= {16'h0, v}) begin
      error_cnt++;
      $display("[FAIL] %0t counter never wrapped", $time);
      results();
    end
    chk(rd, 32'h1);
    apb(1'b0, `OFF_PERIOD, 32'h0); chk(rd, 32'h3);
    $display("Update timing test done");
    // Zero period on purpose
    apb(1'b1, `OFF_PERIOD, 32'h0);
    apb(1'b1, `OFF_UPDATE, 32'h5);
    apb(1'b0, `OFF_PERIOD, 32'h0); chk(rd, 32'h0);
    apb(1'b1, `OFF_DISABLE, 32'h1);
    apb(1'b0, `OFF_STATUS, 32'h0); chk(rd, 32'h0);
    apb(1'b1, `OFF_PERIOD, 32'h4);
    apb(1'b1, `OFF_ENABLE, 32'h1);
    apb(1'b1, `OFF_DISABLE, 32'h1);
    apb(1'b0, `OFF_STATUS, 32'h0); chk(rd, 32'h1);
    chk({31'h0, pwmOut}, 32'h0);
    $display("Zero period and early disable test done");
    results();
  end
endmodule // testbench
